// [rtl/dcfg_event_flags.sv]
// Sticky event flag register: set by hardware pulses, cleared by software.
// Assumes set and clear vectors come from logic on the same clock.
`default_nettype none
module dcfg_event_flags
   import dcfg_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // Events and clears
   input  wire logic [7:0] setPulse,
   input  wire logic [7:0] clearMask,
   // Flags
   output logic      [7:0] flags
);

   logic [7:0] flags_r;
   logic [7:0] flags_nxt;

   // A set in the cycle of its own clear wins, so no event is lost.
   assign flags_nxt = ((flags_r & ~clearMask) | setPulse) & FLAG_MASK;

   always_ff @(posedge clock) begin
      if (reset) begin
         flags_r <= FLAG_RESET;
      end else begin
         flags_r <= flags_nxt; // RL15 RL16
      end
   end

   assign flags = flags_r;

endmodule
`default_nettype wire

// [rtl/dcfg_pkg.sv]
// Constants shared by the device configuration register bank.
// Assumes a single 50 MHz clock and an 8-bit register space.
`default_nettype none
package dcfg_pkg;

   // Register addresses on the serial port.
   localparam logic [6:0] COMM_ADDR  = 7'h00;
   localparam logic [6:0] PWR_ADDR   = 7'h01;
   localparam logic [6:0] FMT_ADDR   = 7'h03;
   localparam logic [6:0] IRQEN_ADDR = 7'h04;
   localparam logic [6:0] FLAG_ADDR  = 7'h06;

   // Serial communication control fields.
   localparam int COMM_SDIO_BIT = 7;
   localparam int COMM_LSBF_BIT = 6;
   localparam int COMM_RST_BIT  = 5;

   // Power control fields.
   localparam int PWR_DACI_BIT = 7;
   localparam int PWR_DACQ_BIT = 6;
   localparam int PWR_RX_BIT   = 5;
   localparam int PWR_AUX_BIT  = 4;
   localparam int PWR_LOCK_BIT = 0;

   // Input data format fields.
   localparam int FMT_BIN_BIT    = 7;
   localparam int FMT_QFIRST_BIT = 6;
   localparam int FMT_SWAP_BIT   = 5;
   localparam int FMT_WIDTH_LSB  = 0;

   // Event flag and interrupt enable positions (same in both registers).
   localparam int EV_PLL_LOST_BIT  = 7;
   localparam int EV_PLL_LOCK_BIT  = 6;
   localparam int EV_SYNC_LOST_BIT = 5;
   localparam int EV_SYNC_LOCK_BIT = 4;
   localparam int EV_CLK_RDY_BIT   = 3;
   localparam int EV_FIFO_SYNC_BIT = 2;

   // Writable bits of each register; all others read as zero, except power bit PWR_LOCK_BIT, which reads PLL lock.
   localparam logic [7:0] COMM_WMASK  = 8'hE0;
   localparam logic [7:0] PWR_WMASK   = 8'hF0;
   localparam logic [7:0] FMT_WMASK   = 8'hE3;
   localparam logic [7:0] IRQEN_WMASK = 8'hFC;
   localparam logic [7:0] FLAG_MASK   = 8'hFC;

   // Reset values.
   localparam logic [7:0] COMM_RESET  = 8'h00;
   localparam logic [7:0] PWR_RESET   = 8'h00;
   localparam logic [7:0] FMT_RESET   = 8'h00;
   localparam logic [7:0] IRQEN_RESET = 8'h00;
   localparam logic [7:0] FLAG_RESET  = 8'h00;

   // Serial frame: one instruction byte, then one data byte.
   localparam logic [2:0] LAST_BIT = 3'h7;

   typedef enum logic [1:0] {
      WIDTH_DUAL    = 2'b00,
      WIDTH_WORD    = 2'b01,
      WIDTH_BYTE    = 2'b10,
      WIDTH_INVALID = 2'b11
   } dcfg_width_e;

endpackage
`default_nettype wire

// [rtl/dcfg_regs.sv]
// Device configuration register bank reached over the serial control port.
// Assumes the host's serial clock is at most one eighth of clock, since all
// port pins are oversampled after a two flip-flop synchroniser.
//
// How it works
// RL1 - Comm bit 7 makes data pin bidirectional.
// RL2 - Comm bit 6 selects LSB-first serial order.
// RL3 - Comm bit 5 holds device reset until cleared.
// RL4 - Power bits 7, 6 power down I, Q.
// RL5 - Power bit 5 powers down data receiver.
// RL6 - Power bit 4 powers down temperature ADC.
// RL7 - Format bit 7 selects offset binary coding.
// RL8 - Format bit 6 selects Q word first.
// RL9 - Format bit 5 reverses input bit order.
// RL10 - Format bits 1:0 select receiver bus width.
// RL11 - Enable bits 7, 6: PLL lost, locked.
// RL12 - Enable bits 5, 4: sync lost, locked.
// RL13 - Enable bit 3: clock generation ready.
// RL14 - Enable bit 2: soft FIFO reset done.
// RL15 - PLL lock-lost flag latches until cleared.
// RL16 - Soft FIFO sync flag latches on completion.
// RL17 - Interrupt follows any enabled set flag.
// RL18 - All control bits reset to zero.
`default_nettype none
module dcfg_regs
   import dcfg_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // Serial control port
   input  wire logic       portSelect_n,
   input  wire logic       portClock,
   input  wire logic       sdioIn,
   output logic            sdioOut,
   output logic            sdioOe,
   output logic            sdoOut,
   output logic            sdoOe,
   // Status from the rest of the device
   input  wire logic       pllLocked,
   input  wire logic       syncLocked,
   input  wire logic       clockReady,
   input  wire logic       fifoSyncDone,
   // Configuration outputs
   output logic            deviceReset,
   output logic            dacIPowerDown,
   output logic            dacQPowerDown,
   output logic            receiverPowerDown,
   output logic            tempAdcPowerDown,
   output logic            offsetBinary,
   output logic            qWordFirst,
   output logic            inputBitSwap,
   output logic      [1:0] busWidth,
   // Interrupt indication
   output logic            interruptActive
);

   typedef enum logic [1:0] {
      PH_IDLE  = 2'b00,
      PH_INSTR = 2'b01,
      PH_DATA  = 2'b10,
      PH_DONE  = 2'b11
   } dcfg_phase_e;

   // Shift one received bit into a byte in the chosen serial order.
   function automatic logic [7:0] shiftBit(input logic [7:0] sh,
                                           input logic       bitIn,
                                           input logic       lsbFirst);
      shiftBit = lsbFirst ? {bitIn, sh[7:1]} : {sh[6:0], bitIn};
   endfunction

   // Pick the k-th bit to send of a byte in the chosen serial order.
   function automatic logic pickBit(input logic [7:0] value,
                                    input logic [2:0] k,
                                    input logic       lsbFirst);
      pickBit = lsbFirst ? value[k] : value[LAST_BIT - k];
   endfunction

   // Synchronised pins.
   logic [6:0] pinSync;
   logic       sclkS;
   logic       csnS;
   logic       sdiS;
   logic [3:0] statusS;

   dcfg_sync2 #(
      .WIDTH (7)
   ) u_sync (
      .clock  (clock),
      .reset  (reset),
      .async  ({fifoSyncDone, clockReady, syncLocked, pllLocked,
                sdioIn, portSelect_n, portClock}),
      .synced (pinSync)
   );

   assign sclkS   = pinSync[0];
   assign csnS    = pinSync[1];
   assign sdiS    = pinSync[2];
   assign statusS = pinSync[6:3];

   // Registers.
   logic [7:0]  comm_r;
   logic [7:0]  pwr_r;
   logic [7:0]  fmt_r;
   logic [7:0]  irqEn_r;
   logic [7:0]  flags;
   logic        sclkPrev_r;
   logic [3:0]  statusPrev_r;
   dcfg_phase_e phase_r;
   logic [2:0]  bitCnt_r;
   logic [7:0]  shift_r;
   logic        isRead_r;
   logic [6:0]  addr_r;
   logic [7:0]  outByte_r;
   logic [2:0]  outCnt_r;
   logic        outBit_r;
   logic        drive_r;
   logic        irq_r;

   // Serial edge and frame decode.
   logic        sclkRise;
   logic        sclkFall;
   logic        lsbFirst;
   logic        bidir;
   logic        softRst;
   logic [7:0]  newByte;
   logic        byteDone;
   logic        wrEn;
   logic [7:0]  wrData;
   logic        readStart;
   logic [7:0]  readData;

   assign sclkRise  = sclkS & ~sclkPrev_r;
   assign sclkFall  = ~sclkS & sclkPrev_r;
   assign lsbFirst  = comm_r[COMM_LSBF_BIT];
   assign bidir     = comm_r[COMM_SDIO_BIT];
   assign softRst   = comm_r[COMM_RST_BIT];
   assign newByte   = shiftBit(shift_r, sdiS, lsbFirst); // RL2
   assign byteDone  = sclkRise & (bitCnt_r == LAST_BIT);
   assign wrEn      = byteDone & (phase_r == PH_DATA) & ~isRead_r;
   assign wrData    = newByte;
   assign readStart = byteDone & (phase_r == PH_INSTR) & newByte[7];

   // Address decode of the write.
   logic wrComm;
   logic wrPwr;
   logic wrFmt;
   logic wrIrqEn;
   logic wrFlag;

   assign wrComm  = wrEn & (addr_r == COMM_ADDR);
   assign wrPwr   = wrEn & (addr_r == PWR_ADDR);
   assign wrFmt   = wrEn & (addr_r == FMT_ADDR);
   assign wrIrqEn = wrEn & (addr_r == IRQEN_ADDR);
   assign wrFlag  = wrEn & (addr_r == FLAG_ADDR);

   // Read multiplexer; unmapped addresses read as zero.
   logic [6:0] rdAddr;
   logic [7:0] pwrView;

   assign rdAddr  = newByte[6:0];
   assign pwrView = (pwr_r & PWR_WMASK) |
                    {7'h00, statusS[0]} << PWR_LOCK_BIT;
   assign readData = (rdAddr == COMM_ADDR)  ? comm_r  :
                     (rdAddr == PWR_ADDR)   ? pwrView :
                     (rdAddr == FMT_ADDR)   ? fmt_r   :
                     (rdAddr == IRQEN_ADDR) ? irqEn_r :
                     (rdAddr == FLAG_ADDR)  ? flags   : 8'h00;

   // Serial port sequencer.
   always_ff @(posedge clock) begin
      if (reset) begin
         sclkPrev_r <= 1'b0;
         phase_r    <= PH_IDLE;
         bitCnt_r   <= 3'h0;
         shift_r    <= 8'h00;
         isRead_r   <= 1'b0;
         addr_r     <= 7'h00;
      end else begin
         sclkPrev_r <= sclkS;
         if (csnS) begin
            phase_r  <= PH_IDLE;
            bitCnt_r <= 3'h0;
         end else if (sclkRise) begin
            shift_r  <= newByte;
            bitCnt_r <= bitCnt_r + 3'h1;
            unique case (phase_r)
               PH_IDLE: begin
                  phase_r <= PH_INSTR;
               end
               PH_INSTR: begin
                  if (byteDone) begin
                     isRead_r <= newByte[7];
                     addr_r   <= newByte[6:0];
                     phase_r  <= PH_DATA;
                  end
               end
               PH_DATA: begin
                  if (byteDone) begin
                     phase_r <= PH_DONE;
                  end
               end
               PH_DONE: begin
                  phase_r <= PH_DONE;
               end
            endcase
         end
      end
   end

   // Read data leaves on falling serial edges after the instruction.
   always_ff @(posedge clock) begin
      if (reset) begin
         outByte_r <= 8'h00;
         outCnt_r  <= 3'h0;
         outBit_r  <= 1'b0;
         drive_r   <= 1'b0;
      end else if (csnS) begin
         outCnt_r <= 3'h0;
         drive_r  <= 1'b0;
      end else if (readStart) begin
         outByte_r <= readData;
         outCnt_r  <= 3'h0;
      end else if (sclkFall & isRead_r & (phase_r == PH_DATA)) begin
         outBit_r <= pickBit(outByte_r, outCnt_r, lsbFirst); // RL2
         outCnt_r <= outCnt_r + 3'h1;
         drive_r  <= 1'b1;
      end
   end

   // Read data uses the shared pin when bidirectional, else the output pin.
   assign sdioOut = outBit_r;
   assign sdoOut  = outBit_r;
   assign sdioOe  = drive_r & bidir; // RL1
   assign sdoOe   = drive_r & ~bidir; // RL1

   // Serial communication control stays writable during its own soft reset,
   // otherwise the device could never be released.
   always_ff @(posedge clock) begin
      if (reset) begin
         comm_r <= COMM_RESET; // RL18
      end else if (wrComm) begin
         comm_r <= wrData & COMM_WMASK; // RL1 RL2 RL3
      end
   end

   always_ff @(posedge clock) begin
      if (reset | softRst) begin
         pwr_r   <= PWR_RESET; // RL3 RL18
         fmt_r   <= FMT_RESET;
         irqEn_r <= IRQEN_RESET;
      end else begin
         if (wrPwr) begin
            pwr_r <= wrData & PWR_WMASK; // RL4 RL5 RL6
         end
         if (wrFmt) begin
            fmt_r <= wrData & FMT_WMASK; // RL7 RL8 RL9 RL10
         end
         if (wrIrqEn) begin
            irqEn_r <= wrData & IRQEN_WMASK; // RL11 RL12 RL13 RL14
         end
      end
   end

   // Status edges become event pulses.
   logic [7:0] evSet;
   logic [7:0] evClear;

   always_ff @(posedge clock) begin
      if (reset) begin
         statusPrev_r <= 4'h0;
      end else begin
         statusPrev_r <= statusS;
      end
   end

   always_comb begin
      evSet = 8'h00;
      evSet[EV_PLL_LOST_BIT]  = statusPrev_r[0] & ~statusS[0]; // RL15
      evSet[EV_PLL_LOCK_BIT]  = ~statusPrev_r[0] & statusS[0];
      evSet[EV_SYNC_LOST_BIT] = statusPrev_r[1] & ~statusS[1];
      evSet[EV_SYNC_LOCK_BIT] = ~statusPrev_r[1] & statusS[1];
      evSet[EV_CLK_RDY_BIT]   = ~statusPrev_r[2] & statusS[2];
      evSet[EV_FIFO_SYNC_BIT] = ~statusPrev_r[3] & statusS[3]; // RL16
   end

   assign evClear = wrFlag ? wrData : 8'h00;

   dcfg_event_flags u_flags (
      .clock     (clock),
      .reset     (reset | softRst),
      .setPulse  (evSet),
      .clearMask (evClear),
      .flags     (flags)
   );

   always_ff @(posedge clock) begin
      if (reset) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(flags & irqEn_r); // RL11 RL12 RL13 RL14 RL17
      end
   end

   // Configuration outputs straight from their register bits.
   assign deviceReset       = softRst; // RL3
   assign dacIPowerDown     = pwr_r[PWR_DACI_BIT]; // RL4
   assign dacQPowerDown     = pwr_r[PWR_DACQ_BIT]; // RL4
   assign receiverPowerDown = pwr_r[PWR_RX_BIT]; // RL5
   assign tempAdcPowerDown  = pwr_r[PWR_AUX_BIT]; // RL6
   assign offsetBinary      = fmt_r[FMT_BIN_BIT]; // RL7
   assign qWordFirst        = fmt_r[FMT_QFIRST_BIT]; // RL8
   assign inputBitSwap      = fmt_r[FMT_SWAP_BIT]; // RL9
   assign busWidth          = fmt_r[FMT_WIDTH_LSB +: 2]; // RL10
   assign interruptActive   = irq_r;

endmodule
`default_nettype wire

// [rtl/dcfg_sync2.sv]
// Two flip-flop synchroniser for a group of independent levels.
// Assumes each bit is a slow level; no bus coherence is given.
`default_nettype none
module dcfg_sync2 #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             reset,
   // Levels
   input  wire logic [WIDTH-1:0] async,
   output logic      [WIDTH-1:0] synced
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] stable_r;

   always_ff @(posedge clock) begin
      if (reset) begin
         meta_r   <= '0;
         stable_r <= '0;
      end else begin
         meta_r   <= async;
         stable_r <= meta_r;
      end
   end

   assign synced = stable_r;

endmodule
`default_nettype wire

// [test/dcfg_host_model.sv]
// Host model driving the four-wire serial control port.
// Assumes mode 0 framing with half periods well above the sync delay.
`default_nettype none
module dcfg_host_model (
   // Clock
   input  wire logic clock,
   // Serial port
   output logic      portSelect_n,
   output logic      portClock,
   output logic      sdioIn,
   input  wire logic sdioOut,
   input  wire logic sdioOe,
   input  wire logic sdoOut,
   input  wire logic sdoOe
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HALF = 6;
   logic       lsbFirst = 1'b0;
   logic       hostDrive = 1'b0;
   logic       hostBit = 1'b0;
   logic [1:0] lastOe = 2'b00;
   // A released line shows the inverse of its last level, not a hold.
   assign sdioIn = sdioOe ? sdioOut : (hostDrive ? hostBit : ~hostBit);
   initial begin
      portSelect_n = 1'b1;
      portClock = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // The serial clock stands low between frames.
   task automatic xfer(input logic rd, input logic [6:0] a,
                       input logic [7:0] wd, output logic [7:0] rdata);
      logic [15:0] f;
      int          k;
      f = {rd, a, wd};
      rdata = 8'h00;
      portSelect_n = 1'b0;
      for (int i = 0; i < 16; i++) begin
         k = lsbFirst ? i % 8 : 7 - i % 8;
         hostDrive = !(rd && i > 7);
         hostBit = f[(i < 8 ? 8 : 0) + k];
         wait_clk(HALF);
         lastOe = {sdioOe, sdoOe};
         rdata[k] = sdoOe ? sdoOut : sdioIn;
         portClock = 1'b1;
         wait_clk(HALF);
         portClock = 1'b0;
      end
      wait_clk(HALF);
      portSelect_n = 1'b1;
      hostDrive = 1'b0;
      wait_clk(8);
   endtask
endmodule
`default_nettype wire

// [test/dcfg_regs_sva.sv]
// Checker for the configuration register bank ports.
// Assumes it is bound to dcfg_regs on its single clock.
`default_nettype none
module dcfg_regs_sva (
   // Clock and reset
   input wire logic       clock,
   input wire logic       reset,
   // Serial port
   input wire logic       portSelect_n,
   input wire logic       sdioOe,
   input wire logic       sdoOe,
   // Status
   input wire logic       pllLocked,
   input wire logic       syncLocked,
   input wire logic       clockReady,
   input wire logic       fifoSyncDone,
   // Outputs
   input wire logic       deviceReset,
   input wire logic       dacIPowerDown,
   input wire logic       tempAdcPowerDown,
   input wire logic       offsetBinary,
   input wire logic [1:0] busWidth,
   input wire logic       interruptActive
);
   timeunit 1ns;
   timeprecision 100ps;
   wire logic [4:0] cfg;
   wire logic [3:0] st;
   assign cfg = {dacIPowerDown, tempAdcPowerDown, offsetBinary, busWidth};
   assign st = {pllLocked, syncLocked, clockReady, fifoSyncDone};
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   property p_oe_excl;
      !(sdioOe && sdoOe);
   endproperty
   a_oe_excl: assert property (p_oe_excl) else $error("both driven");
   property p_oe_idle;
      portSelect_n [*5] |-> !(sdioOe || sdoOe);
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("idle drive");
   property p_oe_frame;
      $rose(sdioOe || sdoOe) |-> !portSelect_n;
   endproperty
   a_oe_frame: assert property (p_oe_frame) else $error("oe out");
   property p_soft;
      deviceReset [*2] |-> cfg == 5'h00;
   endproperty
   a_soft: assert property (p_soft) else $error("cfg in reset");
   property p_irq_soft;
      deviceReset [*3] |-> !interruptActive;
   endproperty
   a_irq_soft: assert property (p_irq_soft) else $error("irq");
   property p_cfg_hold;
      portSelect_n [*6] |-> $stable(cfg);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("cfg moved");
   property p_irq_hold;
      ($stable(st) && portSelect_n) [*6] |-> $stable(interruptActive);
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq moved");
   property p_rst_vals;
      $fell(reset) |-> !deviceReset && cfg == 5'h00 && !interruptActive;
   endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("reset val");
endmodule
bind dcfg_regs dcfg_regs_sva u_dcfg_regs_sva (
   .clock, .reset, .portSelect_n, .sdioOe, .sdoOe, .pllLocked,
   .syncLocked, .clockReady, .fifoSyncDone, .deviceReset,
   .dacIPowerDown, .tempAdcPowerDown, .offsetBinary, .busWidth,
   .interruptActive
);
`default_nettype wire

// [test/dcfg_regs_tb_top.sv]
// Self-checking bench for the configuration register bank.
// Assumes the host model owns the serial port pins.
`default_nettype none
`define CHK(got, exp) check(16'(got), 16'(exp))
module dcfg_regs_tb_top
   import dcfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic            clock = 1'b0;
   logic            reset = 1'b1;
   logic      [3:0] st = 4'h0;
   wire logic       portSelect_n, portClock, sdioIn, sdioOut, sdioOe;
   wire logic       sdoOut, sdoOe, deviceReset, dacIPowerDown;
   wire logic       dacQPowerDown, receiverPowerDown, tempAdcPowerDown;
   wire logic       offsetBinary, qWordFirst, inputBitSwap, interruptActive;
   wire logic [1:0] busWidth;
   int              miscompares = 0;
   int              nCompared = 0;
   logic      [7:0] rdat;
   logic      [7:0] fv;
   logic      [6:0] addrs [5] = '{COMM_ADDR, PWR_ADDR, FMT_ADDR,
                                   IRQEN_ADDR, FLAG_ADDR};
   logic      [7:0] ens [4] = '{8'h40, 8'h10, 8'h08, 8'h04};
   always #10 clock = ~clock;
   dcfg_regs u_dcfg_regs (
      .clock, .reset, .portSelect_n, .portClock, .sdioIn, .sdioOut,
      .sdioOe, .sdoOut, .sdoOe, .pllLocked(st[3]), .syncLocked(st[2]),
      .clockReady(st[1]), .fifoSyncDone(st[0]), .deviceReset,
      .dacIPowerDown, .dacQPowerDown, .receiverPowerDown,
      .tempAdcPowerDown, .offsetBinary, .qWordFirst, .inputBitSwap,
      .busWidth, .interruptActive
   );
   dcfg_host_model u_dcfg_host_model (
      .clock, .portSelect_n, .portClock, .sdioIn, .sdioOut, .sdioOe,
      .sdoOut, .sdoOe
   );
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      nCompared++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      u_dcfg_host_model.xfer(1'b0, a, d, rdat);
   endtask
   task automatic chkRd(input logic [6:0] a, input logic [7:0] e);
      u_dcfg_host_model.xfer(1'b1, a, 8'h00, rdat);
      `CHK(rdat, e);
   endtask
   task automatic setSt(input logic [3:0] s);
      st = s;
      repeat (8) @(posedge clock);
      #1;
   endtask
   task automatic tally_and_finish;
      $display("Compared %0d, mismatches %0d", nCompared, miscompares);
      if (miscompares == 0 && nCompared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clock);
      miscompares++;
      tally_and_finish();
   end
   initial begin
      repeat (16) @(posedge clock);
      #1 reset = 1'b0;
      repeat (4) @(posedge clock);
      #1;
      `CHK({deviceReset, dacIPowerDown, dacQPowerDown, receiverPowerDown,
            tempAdcPowerDown, offsetBinary, qWordFirst, inputBitSwap,
            busWidth, interruptActive}, 11'h000);
      foreach (addrs[i]) chkRd(addrs[i], 8'h00);
      wr(PWR_ADDR, 8'hFF);
      `CHK({dacIPowerDown, dacQPowerDown, receiverPowerDown,
            tempAdcPowerDown}, 4'hF);
      chkRd(PWR_ADDR, 8'hF0);
      `CHK(u_dcfg_host_model.lastOe, 2'b01);
      wr(PWR_ADDR, 8'h50);
      `CHK({dacIPowerDown, dacQPowerDown, receiverPowerDown,
            tempAdcPowerDown}, 4'h5);
      for (int w = 0; w < 4; w++) begin
         // Width code 11 is forbidden to the host, so the last pass uses 00.
         fv = {w[0], w[1], ~w[0], 3'h0, 2'(w % 3)};
         wr(FMT_ADDR, fv);
         `CHK({offsetBinary, qWordFirst, inputBitSwap, busWidth},
              {fv[7:5], fv[1:0]});
         chkRd(FMT_ADDR, fv);
      end
      wr(7'h02, 8'hFF);
      chkRd(7'h02, 8'h00);
      chkRd(PWR_ADDR, 8'h50);
      wr(IRQEN_ADDR, 8'h00);
      setSt(4'hF);
      `CHK(interruptActive, 1'b0);
      chkRd(FLAG_ADDR, 8'h5C);
      chkRd(PWR_ADDR, 8'h51);
      foreach (ens[i]) begin
         wr(IRQEN_ADDR, ens[i]);
         `CHK(interruptActive, 1'b1);
      end
      setSt(4'h3);
      wr(IRQEN_ADDR, 8'h80);
      `CHK(interruptActive, 1'b1);
      wr(IRQEN_ADDR, 8'h20);
      `CHK(interruptActive, 1'b1);
      // Relocking must leave the latched lock-lost flag standing.
      setSt(4'hB);
      chkRd(FLAG_ADDR, 8'hFC);
      wr(FLAG_ADDR, 8'h80);
      chkRd(FLAG_ADDR, 8'h7C);
      wr(IRQEN_ADDR, 8'h84);
      `CHK(interruptActive, 1'b1);
      wr(FLAG_ADDR, 8'h7C);
      `CHK(interruptActive, 1'b0);
      wr(COMM_ADDR, 8'h40);
      u_dcfg_host_model.lsbFirst = 1'b1;
      wr(FMT_ADDR, 8'hC2);
      `CHK({offsetBinary, qWordFirst, busWidth}, 4'hE);
      chkRd(FMT_ADDR, 8'hC2);
      wr(COMM_ADDR, 8'h80);
      u_dcfg_host_model.lsbFirst = 1'b0;
      chkRd(COMM_ADDR, 8'h80);
      `CHK(u_dcfg_host_model.lastOe, 2'b10);
      // A fresh FIFO sync event raises the interrupt before the soft reset.
      setSt(4'hA);
      setSt(4'hB);
      `CHK(interruptActive, 1'b1);
      wr(COMM_ADDR, 8'h20);
      `CHK({deviceReset, dacQPowerDown, tempAdcPowerDown, qWordFirst,
            busWidth, interruptActive}, 7'h40);
      wr(PWR_ADDR, 8'hF0);
      chkRd(PWR_ADDR, 8'h01);
      chkRd(FLAG_ADDR, 8'h00);
      wr(COMM_ADDR, 8'h00);
      `CHK(deviceReset, 1'b0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
